//--- ecc_ctrl_top.sv
// excitation current control register and analog control outputs
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module ecc_ctrl_top (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // register port
  input  wire logic [31:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // analog current source controls
  output logic             source_a_enable,
  output logic             source_b_enable,
  output logic             source_a_route,
  output logic             source_b_route,
  output logic      [2:0]  current_level_code,
  output logic             diagnostic_current_enable,
  // decoded level per source, zero when disabled
  output logic      [10:0] excitation_source_a,
  output logic      [10:0] excitation_source_b,
  output logic             level_code_valid
);

  ////////////////////////////////////////////////////////////////////////////

  logic [7:0]  ctrl_reg;
  logic        hit;
  logic [10:0] level_ua;

  assign hit = (reg_addr == ecc_pkg::EXC_CTRL_ADDR);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_reg <= ecc_pkg::EXC_CTRL_RESET;
    end else if (reg_wr && hit) begin
      ctrl_reg <= reg_wdata;
    end
  end

  // unmapped reads return zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= ecc_pkg::READ_ZERO;
    end else if (reg_rd && hit) begin
      reg_rdata <= ctrl_reg;
    end else begin
      reg_rdata <= ecc_pkg::READ_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign source_b_enable = ctrl_reg[ecc_pkg::SRC_B_EN_BIT];
  assign source_a_enable = ctrl_reg[ecc_pkg::SRC_A_EN_BIT];
  assign source_b_route  = ctrl_reg[ecc_pkg::SRC_B_ROUTE_BIT];
  assign source_a_route  = ctrl_reg[ecc_pkg::SRC_A_ROUTE_BIT];
  assign current_level_code =
    ctrl_reg[ecc_pkg::LEVEL_HI:ecc_pkg::LEVEL_LO];
  assign diagnostic_current_enable = ctrl_reg[ecc_pkg::DIAG_BIT];

  ecc_level_decode u_dec (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .level_code  (current_level_code),
    .diag_en     (diagnostic_current_enable),
    .current_ua  (level_ua),
    .level_valid (level_code_valid)
  );

  // decoded level lags the register by one cycle
  assign excitation_source_a = source_a_enable ? level_ua : 11'h000;
  assign excitation_source_b = source_b_enable ? level_ua : 11'h000;

  ////////////////////////////////////////////////////////////////////////////

  reset_zero_a: assert property (@(posedge mclk)
    !rst_n |=> ctrl_reg == 8'h00 && !source_a_enable)
    else $error("register not cleared by reset");

  src_b_en_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && hit |=> source_b_enable == $past(reg_wdata[7]))
    else $error("source b enable mismatch");

  src_a_en_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && hit |=> source_a_enable == $past(reg_wdata[6]))
    else $error("source a enable mismatch");

  src_b_route_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && hit |=> source_b_route == $past(reg_wdata[5]))
    else $error("source b route mismatch");

  src_a_route_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && hit |=> source_a_route == $past(reg_wdata[4]))
    else $error("source a route mismatch");

  level_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && hit && reg_wdata == 8'h46 ##1 !reg_wr [*2]
    |-> excitation_source_a == 11'h258)
    else $error("level 3 not 600 uA");

  diag_add_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && hit && reg_wdata == 8'h41 ##1 !reg_wr [*2]
    |-> excitation_source_a == 11'h00A)
    else $error("diagnostic current not 10 uA");

  read_back_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reg_wr && hit ##1 reg_rd && hit && !reg_wr
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("read back differs from write");

  hold_val_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !(reg_wr && hit) |=> $stable(ctrl_reg))
    else $error("register changed without write");

endmodule

//--- ecc_level_decode.sv
// level code to current decoder for the excitation sources
`timescale 1ns/1ps
module ecc_level_decode (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // control fields
  input  wire logic [2:0]  level_code,
  input  wire logic        diag_en,
  // decoded current in microamps, registered
  output logic      [10:0] current_ua,
  output logic             level_valid
);

  logic [10:0] current_next;

  always_comb begin
    case (level_code)
      3'h0:    current_next = 11'h000;
      3'h1:    current_next = 11'h0C8;
      3'h2:    current_next = 11'h190;
      3'h3:    current_next = 11'h258;
      3'h4:    current_next = 11'h320;
      3'h5:    current_next = 11'h3E8;
      default: current_next = 11'h000;
    endcase
    // diagnostic current rides on top of the coded level
    if (diag_en) begin
      current_next = current_next + 11'h00A;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      current_ua  <= 11'h000;
      level_valid <= 1'b1;
    end else begin
      current_ua  <= current_next;
      // undefined codes flagged rather than trapped
      level_valid <= (level_code <= ecc_pkg::LEVEL_MAX_CODE);
    end
  end

endmodule

//--- ecc_pkg.sv
// constants for the excitation current control register bank
// Operation
// - one 8-bit register, resets to zero
// - bit 7 enables source b
// - bit 6 enables source a
// - bit 5 routes source b to pin a
// - bit 4 routes source a to pin b
// - bits 3:1 select level 0 to 1 mA
// - bit 0 adds 10 uA diagnostic current
package ecc_pkg;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 8;

  localparam logic [31:0] EXC_CTRL_ADDR  = 32'hFFFF0570;
  localparam logic [7:0]  EXC_CTRL_RESET = 8'h00;

  localparam int unsigned SRC_B_EN_BIT    = 7;
  localparam int unsigned SRC_A_EN_BIT    = 6;
  localparam int unsigned SRC_B_ROUTE_BIT = 5;
  localparam int unsigned SRC_A_ROUTE_BIT = 4;
  localparam int unsigned LEVEL_HI        = 3;
  localparam int unsigned LEVEL_LO        = 1;
  localparam int unsigned DIAG_BIT        = 0;

  localparam logic [2:0] LEVEL_MAX_CODE = 3'h5;
  localparam logic [7:0] READ_ZERO      = 8'h00;

endpackage

//--- test_excitation_current_control.sv
// self-checking bench for the excitation current control register
`timescale 1ns/1ps
module test_excitation_current_control;
  localparam logic [31:0] A = ecc_pkg::EXC_CTRL_ADDR;
  logic        mclk, rst_n, reg_wr, reg_rd;
  logic [31:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rv;
  logic        a_en, b_en, a_rt, b_rt, diag, lvl_ok;
  logic [2:0]  lvl;
  logic [10:0] cur_a, cur_b;
  int          err_count, n_compared;
  ecc_ctrl_top i_ecc_ctrl_top (.mclk(mclk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .source_a_enable(a_en),
    .source_b_enable(b_en), .source_a_route(a_rt), .source_b_route(b_rt),
    .current_level_code(lvl), .diagnostic_current_enable(diag),
    .excitation_source_a(cur_a), .excitation_source_b(cur_b),
    .level_code_valid(lvl_ok));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // called just after a rising edge; returns just after the sampling edge
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    @(negedge mclk);
    rv = reg_rdata;
    @(posedge mclk);
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // whole run needs well under 200 cycles
  initial begin
    #100000;
    err_count++;
    finish_test();
  end
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 32'h00000000;
    reg_wdata = 8'h00;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(A);
    chk(rv, 8'h00);
    chk({a_en, b_en, a_rt, b_rt, lvl, diag, cur_a}, 19'h00000);
    $display("reset test done");
    for (int c = 0; c < 6; c++) begin
      for (int g = 0; g < 2; g++) begin
        wr(A, {4'hC, c[2:0], g[0]});
        rd(A);
        chk(rv, {4'hC, c[2:0], g[0]});
        chk(cur_a, 11'(c * 200 + g * 10));
        chk(cur_b, 11'(c * 200 + g * 10));
        chk({lvl_ok, lvl, diag}, {1'b1, c[2:0], g[0]});
      end
    end
    wr(A, 8'h46);
    rd(A);
    chk(cur_a, 11'h258);
    wr(A, 8'h41);
    rd(A);
    chk(cur_a, 11'h00A);
    wr(A, 8'h4E);
    rd(A);
    chk({lvl_ok, lvl}, {1'b0, 3'h7});
    chk(cur_a, 11'h000);
    $display("level test done");
    wr(A, 8'hB5);
    rd(A);
    chk({b_en, a_en, b_rt, a_rt}, 4'hB);
    chk(cur_a, 11'h000);
    chk(cur_b, 11'h19A);
    wr(A, 8'h4A);
    rd(A);
    chk({b_en, a_en, b_rt, a_rt}, 4'h4);
    chk(cur_a, 11'h3E8);
    chk(cur_b, 11'h000);
    $display("field test done");
    wr(A + 32'h4, 8'hFF);
    rd(A);
    chk(rv, 8'h4A);
    rd(A + 32'h4);
    chk(rv, 8'h00);
    $display("unmapped test done");
    finish_test();
  end
endmodule
